// File: verilog/prs_pkg.sv
package prs_pkg;
    // ****************************************
    // Register map
    // ****************************************
    localparam logic [9:0] REF_SWITCH_CONTROL_ADDR = 10'h01c;
    localparam logic [7:0] REF_SWITCH_CONTROL_RST = 8'h00;
    localparam int BIT_DIFF_MODE = 0;
    localparam int BIT_PRI_PWR = 1;
    localparam int BIT_SEC_PWR = 2;
    localparam int BIT_STAY_SEC = 3;
    localparam int BIT_AUTO_EN = 4;
    localparam int BIT_USE_PIN = 5;
    localparam int BIT_SEL_SEC = 6;
    localparam int BIT_DEGLITCH_DIS = 7;

    // ****************************************
    // Switchover states
    // ****************************************
    typedef enum logic [1:0] {
        ST_PRIMARY = 2'b01,
        ST_SECONDARY = 2'b10
    } prs_state_t;
endpackage

// File: verilog/prs_sel_sync.sv
`timescale 1ns/1ps
// ****************************************
// Two-stage synchroniser for the select pin
// ****************************************
module prs_sel_sync (
    // Clock and reset
    input wire logic mclk,
    input wire logic rstn,
    // Data
    input wire logic din,
    output logic dout
);
    logic meta_q;

    always_ff @(posedge mclk) begin
        if (!rstn) begin
            meta_q <= 1'b0;
            dout <= 1'b0;
        end else begin
            meta_q <= din;
            dout <= meta_q;
        end
    end
endmodule

// File: verilog/prs_switch_ctrl.sv
`timescale 1ns/1ps
// ****************************************
// Reference switchover control
// ****************************************
module prs_switch_ctrl (
    // Clock and reset
    input wire logic mclk,
    input wire logic rstn,
    // Register port from serial control
    input wire logic reg_wr,
    input wire logic [9:0] reg_addr,
    input wire logic [7:0] reg_wdata,
    output logic [7:0] reg_rdata,
    // Reference monitors and select pin
    input wire logic primary_status_good,
    input wire logic secondary_status_good,
    input wire logic ref_select_pin,
    // Controls to reference path
    output logic use_secondary,
    output logic primary_power_en,
    output logic secondary_power_en,
    output logic diff_mode,
    output logic deglitch_en,
    output logic auto_mode
);
    logic [7:0] ctrl_q;
    logic pin_sync;
    prs_pkg::prs_state_t state_q;
    prs_pkg::prs_state_t state_d;

    // ****************************************
    // Decode helpers
    // ****************************************
    // True when the bus names the switchover control register
    function automatic logic ctrl_hit(input logic [9:0] addr);
        return addr == prs_pkg::REF_SWITCH_CONTROL_ADDR;
    endfunction

    // Reference asked for under manual control, from the pin or the register bit
    function automatic logic manual_choice(input logic [7:0] ctrl, input logic pin);
        logic choice;
        if (ctrl[prs_pkg::BIT_USE_PIN]) begin
            choice = pin;
        end else begin
            choice = ctrl[prs_pkg::BIT_SEL_SEC];
        end
        return choice;
    endfunction

    // An input is powered by its own bit or by automatic switchover
    function automatic logic power_on(input logic [7:0] ctrl, input int en_bit);
        return ctrl[prs_pkg::BIT_AUTO_EN] | ctrl[en_bit];
    endfunction

    // Switchover state that stands for a reference choice
    function automatic prs_pkg::prs_state_t state_of(input logic on_secondary);
        return on_secondary ? prs_pkg::ST_SECONDARY : prs_pkg::ST_PRIMARY;
    endfunction

    // Leave the primary only when there is a good secondary to go to
    function automatic logic failover_wanted(input logic pri_good, input logic sec_good);
        return !pri_good && sec_good;
    endfunction

    // Return to the primary once it is good, unless told to stay
    function automatic logic revert_wanted(input logic [7:0] ctrl, input logic pri_good);
        return !ctrl[prs_pkg::BIT_STAY_SEC] && pri_good;
    endfunction

    // ****************************************
    // Select pin synchroniser
    // ****************************************
    prs_sel_sync u_sync (
        .mclk(mclk),
        .rstn(rstn),
        .din(ref_select_pin),
        .dout(pin_sync)
    );

    // ****************************************
    // Control register
    // ****************************************
    always_ff @(posedge mclk) begin
        if (!rstn) begin
            ctrl_q <= prs_pkg::REF_SWITCH_CONTROL_RST;
        end else if (reg_wr && ctrl_hit(reg_addr)) begin
            ctrl_q <= reg_wdata;
        end
    end

    // ****************************************
    // Read back
    // ****************************************
    always_ff @(posedge mclk) begin
        if (!rstn) begin
            reg_rdata <= '0;
        end else if (ctrl_hit(reg_addr)) begin
            reg_rdata <= ctrl_q;
        end else begin
            reg_rdata <= '0;
        end
    end

    // ****************************************
    // Automatic switchover state
    // ****************************************
    always_comb begin
        state_d = state_q;
        unique case (state_q)
            prs_pkg::ST_PRIMARY: begin
                if (failover_wanted(primary_status_good, secondary_status_good)) begin
                    state_d = prs_pkg::ST_SECONDARY;
                end
            end
            prs_pkg::ST_SECONDARY: begin
                // Revert only when not told to stay
                if (revert_wanted(ctrl_q, primary_status_good)) begin
                    state_d = prs_pkg::ST_PRIMARY;
                end
            end
            default: state_d = prs_pkg::ST_PRIMARY;
        endcase
    end

    always_ff @(posedge mclk) begin
        if (!rstn) begin
            state_q <= prs_pkg::ST_PRIMARY;
        end else if (!ctrl_q[prs_pkg::BIT_AUTO_EN]) begin
            // Track the manual choice so entering automatic mode starts from the
            // reference in use, with no stray pulse on the select
            state_q <= state_of(manual_choice(ctrl_q, pin_sync));
        end else begin
            state_q <= state_d;
        end
    end

    // ****************************************
    // Registered outputs
    // ****************************************
    always_ff @(posedge mclk) begin
        if (!rstn) begin
            use_secondary <= 1'b0;
        end else if (ctrl_q[prs_pkg::BIT_AUTO_EN]) begin
            use_secondary <= (state_q == prs_pkg::ST_SECONDARY);
        end else begin
            use_secondary <= manual_choice(ctrl_q, pin_sync);
        end
    end

    // ****************************************
    // Power enables
    // ****************************************
    always_ff @(posedge mclk) begin
        if (!rstn) begin
            primary_power_en <= power_on(prs_pkg::REF_SWITCH_CONTROL_RST, prs_pkg::BIT_PRI_PWR);
        end else begin
            primary_power_en <= power_on(ctrl_q, prs_pkg::BIT_PRI_PWR);
        end
    end

    always_ff @(posedge mclk) begin
        if (!rstn) begin
            secondary_power_en <= power_on(prs_pkg::REF_SWITCH_CONTROL_RST, prs_pkg::BIT_SEC_PWR);
        end else begin
            secondary_power_en <= power_on(ctrl_q, prs_pkg::BIT_SEC_PWR);
        end
    end

    // ****************************************
    // Mode outputs
    // ****************************************
    always_ff @(posedge mclk) begin
        if (!rstn) begin
            diff_mode <= prs_pkg::REF_SWITCH_CONTROL_RST[prs_pkg::BIT_DIFF_MODE];
        end else begin
            diff_mode <= ctrl_q[prs_pkg::BIT_DIFF_MODE];
        end
    end

    always_ff @(posedge mclk) begin
        if (!rstn) begin
            deglitch_en <= ~prs_pkg::REF_SWITCH_CONTROL_RST[prs_pkg::BIT_DEGLITCH_DIS];
        end else begin
            deglitch_en <= ~ctrl_q[prs_pkg::BIT_DEGLITCH_DIS];
        end
    end

    always_ff @(posedge mclk) begin
        if (!rstn) begin
            auto_mode <= prs_pkg::REF_SWITCH_CONTROL_RST[prs_pkg::BIT_AUTO_EN];
        end else begin
            auto_mode <= ctrl_q[prs_pkg::BIT_AUTO_EN];
        end
    end
endmodule

// File: sim/prs_ref_mon.sv
`timescale 1ns/1ps
module prs_ref_mon (
    // Fault command in, monitor levels out
    input wire logic mclk,
    input wire logic pri_fail,
    input wire logic sec_fail,
    output logic primary_status_good,
    output logic secondary_status_good
);
    always_ff @(posedge mclk) begin
        primary_status_good <= !pri_fail;
        secondary_status_good <= !sec_fail;
    end
endmodule

// File: sim/prs_switch_checker.sv
`timescale 1ns/1ps
module prs_switch_checker (
    // Watched ports
    input logic mclk, input logic rstn, input logic reg_wr, input logic [9:0] reg_addr,
    input logic [7:0] reg_wdata, input logic [7:0] reg_rdata, input logic primary_status_good,
    input logic ref_select_pin, input logic use_secondary, input logic primary_power_en,
    input logic secondary_power_en, input logic auto_mode
);
    default clocking @(posedge mclk); endclocking
    default disable iff (!rstn);
    wire logic w = reg_wr && reg_addr == 10'h01c;
    a_auto_bit: assert property (w |-> ##2 auto_mode == $past(reg_wdata[4], 2))
        else $error("auto mode");
    a_auto_power: assert property (auto_mode |-> primary_power_en && secondary_power_en)
        else $error("auto power");
    a_man_power: assert property ((w && !reg_wdata[4]) |-> ##2
        {secondary_power_en, primary_power_en} == $past(reg_wdata[2:1], 2)) else $error("power");
    a_reg_select: assert property ((w && reg_wdata[5:4] == 2'b00) ##1 !w |-> ##1
        use_secondary == $past(reg_wdata[6], 2)) else $error("register select");
    a_pin_select: assert property ((w && reg_wdata[5:4] == 2'b10) ##1 !w [*4] |->
        use_secondary == $past(ref_select_pin, 3)) else $error("pin select");
    a_revert_pri: assert property ((reg_rdata[4:3] == 2'b10 && primary_status_good) [*3]
        |-> ##[0:2] !use_secondary) else $error("no revert");
    a_stay_sec: assert property ((reg_rdata[4:3] == 2'b11) [*4] ##0 $past(use_secondary)
        |-> use_secondary) else $error("left secondary");
    a_sync_mode: assert property ($changed(auto_mode) |-> $past(w, 2))
        else $error("mode change");
endmodule
bind prs_switch_ctrl prs_switch_checker chk (.mclk, .rstn, .reg_wr, .reg_addr, .reg_wdata,
    .reg_rdata, .primary_status_good, .ref_select_pin, .use_secondary, .primary_power_en,
    .secondary_power_en, .auto_mode);

// File: sim/tb.sv
`timescale 1ns/1ps
module tb;
    logic mclk, rstn, reg_wr, ref_select_pin, pri_fail, on_sec, diff_mode, deglitch_en;
    logic primary_status_good, secondary_status_good, use_secondary, auto_mode;
    logic primary_power_en, secondary_power_en, sec_fail;
    logic [9:0] reg_addr;
    logic [7:0] reg_wdata, reg_rdata, ctrl;
    int n_errors = 0, checked = 0;
    wire logic [15:0] outs = {2'h0, use_secondary, auto_mode, primary_power_en,
        secondary_power_en, diff_mode, deglitch_en, reg_rdata};
    prs_ref_mon mon (.mclk, .pri_fail, .sec_fail, .primary_status_good,
        .secondary_status_good);
    prs_switch_ctrl dut (.mclk, .rstn, .reg_wr, .reg_addr, .reg_wdata, .reg_rdata,
        .primary_status_good, .secondary_status_good, .ref_select_pin, .use_secondary,
        .primary_power_en, .secondary_power_en, .diff_mode, .deglitch_en, .auto_mode);
    task automatic chk(logic [15:0] s, logic [15:0] e);
        checked++;
        n_errors += int'(s !== e);
        if (s !== e) $display("unexpected %0t %h %h", $time, s, e);
    endtask
    task automatic print_verdict();
        if (n_errors == 0 && checked > 0)
            $display("TEST PASSED");
        else
            $display("TEST FAILED");
        $finish;
    endtask
    task automatic look();
        #1 chk(outs, {2'h0, ctrl[4] ? on_sec : ctrl[5] ? ref_select_pin : ctrl[6], ctrl[4],
            ctrl[4] | ctrl[1], ctrl[4] | ctrl[2], ctrl[0], ~ctrl[7], ctrl});
    endtask
    task automatic wr(logic [9:0] a, logic [7:0] d);
        @(posedge mclk) {reg_wr, reg_addr, reg_wdata, ref_select_pin} <= {1'b1, a, d, 1'($urandom)};
        @(posedge mclk) {reg_wr, reg_addr} <= {1'b0, 10'h01c};
        ctrl = (a == 10'h01c) ? d : ctrl;
        repeat (4) @(posedge mclk);
        look();
    endtask
    initial begin
        mclk = 1'b0;
        forever #5 mclk = ~mclk;
    end
    initial begin
        #50000 n_errors++;
        print_verdict();
    end
    initial begin
        {rstn, reg_wr, ref_select_pin, pri_fail, sec_fail, on_sec, ctrl, reg_wdata} = '0;
        reg_addr = 10'h01c;
        void'($urandom(42));
        repeat (5) @(posedge mclk);
        rstn <= 1'b1;
        look();
        for (int i = 0; i < 24; i++)
            wr(10'h01c, 8'($urandom) & 8'hef);
        wr(10'h01d, 8'hff);
        wr(10'h01c, 8'h00);
        for (int s = 0; s < 4; s++) begin
            if (!s[0]) wr(10'h01c, s[1] ? 8'h18 : 8'h10);
            @(posedge mclk) pri_fail <= !s[0];
            on_sec = !s[0] | s[1];
            repeat (5) @(posedge mclk);
            look();
        end
        on_sec = 1'b0;
        wr(10'h01c, 8'h10);
        @(posedge mclk) {pri_fail, sec_fail} <= 2'b11;
        repeat (5) @(posedge mclk);
        look();
        print_verdict();
    end
endmodule
